// File: shared/svs_pkg.sv
package svs_pkg;
  // ==========================================
  // Channels, depth, modules
  localparam int CHANS       = 48;
  localparam int HALF_CHANS  = 24;
  localparam int ADDR_W      = 24;        // 16M vectors in half mode
  localparam int FULL_ADDR_W = 23;        // 8M vectors in full mode
  localparam int MAX_MODULES = 5;
  localparam int CHAIN_BITS  = MAX_MODULES * CHANS;
  localparam int FIFO_DEPTH  = 16;
  // ==========================================
  // Fields of a vector
  localparam int NUM_FIELDS  = 3;
  localparam int FW_W        = 6;
  localparam int MAX_FIELD_W = 32;
  localparam int SUM_W       = 8;
  // ==========================================
  // Clocking
  localparam int REF_MHZ      = 10;       // ref_clk rate
  localparam int CLK_NS       = 100;
  localparam int GEN_W        = 9;
  localparam int ACC_W        = 10;
  localparam int GEN_MIN_MHZ  = 1;
  localparam int FULL_MAX_MHZ = 180;
  localparam int HALF_MAX_MHZ = 300;
  localparam int STROBE_MAX_NS = 8;
  localparam int STROBE_CYC_RAW = STROBE_MAX_NS / CLK_NS;
  localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
  // ==========================================
  // Wait conditions
  localparam int PAT_W    = 3;
  localparam int NUM_PAT  = 8;
  localparam int NUM_COND = 4;
  localparam logic [2:0] COND_EVENT = 3'h4;

  typedef enum logic [1:0] {
    OP_VEC  = 2'b00,
    OP_WAIT = 2'b01,
    OP_ARM  = 2'b10
  } svs_op_e;

  typedef enum logic [1:0] {
    CLK_INT   = 2'b00,
    CLK_EXT   = 2'b01,
    CLK_CHAIN = 2'b10
  } svs_clk_e;

  typedef struct packed {
    svs_op_e            op;
    logic [2:0]         cond;
    logic [CHANS-1:0]   data;
  } svs_word_s;

  typedef struct packed {
    svs_clk_e                             clk_src;
    logic                                 half_mode;
    logic                                 repeat_mode;
    logic                                 strobe_dly;
    logic [GEN_W-1:0]                     gen_mhz;
    logic [NUM_FIELDS-1:0][FW_W-1:0]      fld_width;
    logic [NUM_COND-1:0][NUM_PAT-1:0]     cond_mask;
    logic [ADDR_W-1:0]                    init_first;
    logic [ADDR_W-1:0]                    main_first;
    logic [ADDR_W-1:0]                    main_last;
  } svs_cfg_s;
endpackage : svs_pkg

// File: hw/svs_sequencer.sv
// Behaviour
// - each stored vector appears on the channels at an output clock edge.
// - vector built of fields, each one to 32 bits wide.
// - 48 channels in full mode, 24 in half mode.
// - vector rate capped at 180 MHz full, 300 MHz half.
// - depth 8M vectors full, 16M vectors half.
// - up to five modules share one master time base.
// - each module may instead run on its own clock.
// - clock source is internal generator or external pod clock.
// - internal generator set from 1 to 300 MHz; it ticks every ceil(10/gen_mhz) ref_clk cycles, so at most 10 MHz.
// - strobe follows the vectors with a delay of at most 8 ns; here it lags by one 100 ns ref_clk cycle.
// - repeat mode emits init block once, then loops main sequence.
// - arm instruction raises an event on the intermodule bus.
// - 3-bit pod pattern is level sensed, tested by a wait on conditions 0 to 3.
// - four wait conditions, each an OR of chosen 3-bit patterns.
// - a wait may instead be met by an intermodule bus event.
// - while a wait is false, vector output stalls.
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Word buffer between vector store and sequencer
module svs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } svs_fifo_st_s;
  svs_fifo_st_s s_q, s_d;
  logic push, pop;

  // Full and empty come straight from the count
  assign in_ready  = (s_q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = s_q.wp + PW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + PW'(1);
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : svs_fifo

// ==========================================
// Vector sequencer
module svs_sequencer (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire svs_pkg::svs_cfg_s       cfg,
  input  wire logic                    start,
  input  wire logic                    ext_clk_pin,
  input  wire logic [2:0]              pattern_pins,
  input  wire logic                    intermodule_event_bus,
  input  wire logic                    chain_tick_in,
  output logic                         fetch_valid,
  output logic [23:0]                  fetch_addr,
  input  wire logic                    fetch_ready,
  input  wire logic                    word_valid,
  input  wire svs_pkg::svs_word_s      word_in,
  output logic                         word_ready,
  output logic [47:0]                  chan_out,
  output logic                         vec_clk_out,
  output logic                         strobe_out,
  output logic                         tick_out,
  output logic                         arm_peer_modules,
  output logic                         busy,
  output logic                         waiting,
  output logic                         underrun
);
  import svs_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } svs_state_e;

  typedef struct packed {
    svs_state_e          st;
    logic [ACC_W-1:0]    acc;
    logic                f_on;
    logic                f_main;
    logic [ADDR_W-1:0]   f_addr;
    logic                c_main;
    logic [ADDR_W-1:0]   c_addr;
    logic [CHANS-1:0]    vec;
    logic                vclk;
    logic [STROBE_CYC-1:0] strb;
    logic                arm;
    logic                urun;
    logic [2:0]          ext_sync;
    logic [PAT_W-1:0]    pat_s1;
    logic [PAT_W-1:0]    pat_s2;
  } svs_st_s;

  svs_st_s   q, d;
  svs_word_s fw;
  logic      fw_valid, fw_pop;
  logic      tick, gen_tick, ext_tick, cond_ok, last_c;
  logic [GEN_W-1:0] mhz, mhz_max;
  logic [CHANS-1:0] chan_mask, live_mask;
  logic [SUM_W-1:0] fld_sum;

  // Prefetch buffer; a stalled sequencer backs up into the store
  svs_fifo #(.WIDTH($bits(svs_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (ref_clk),
    .reset     (reset),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_data   (word_in),
    .out_valid (fw_valid),
    .out_ready (fw_pop),
    .out_data  (fw)
  );

  // Address step; full mode folds the top bit to keep 8M depth
  function automatic logic [ADDR_W-1:0] wrap_addr(
    input logic [ADDR_W-1:0] a,
    input logic              half
  );
    logic [ADDR_W-1:0] r;
    r = a;
    if (!half) begin
      r[ADDR_W-1] = 1'b0;
    end
    return r;
  endfunction : wrap_addr

  // Generator rate clamp; rate cannot pass what the mode allows
  always_comb begin
    mhz_max = cfg.half_mode ? GEN_W'(HALF_MAX_MHZ) : GEN_W'(FULL_MAX_MHZ);
    mhz = cfg.gen_mhz;
    if (mhz < GEN_W'(GEN_MIN_MHZ)) begin
      mhz = GEN_W'(GEN_MIN_MHZ);
    end
    if (mhz > mhz_max) begin
      mhz = mhz_max;
    end
  end

  // Generator tick; above ref rate it saturates to every cycle
  assign gen_tick = ((q.acc + ACC_W'(mhz)) >= ACC_W'(REF_MHZ));
  // Edge seen only on the second and third stages
  assign ext_tick = q.ext_sync[1] & ~q.ext_sync[2];

  always_comb begin
    unique case (cfg.clk_src)
      CLK_INT:   tick = gen_tick;
      CLK_EXT:   tick = ext_tick;
      CLK_CHAIN: tick = chain_tick_in;
      default:   tick = 1'b0;
    endcase
  end

  // pattern conditions as OR of patterns
  always_comb begin
    if (fw.cond == COND_EVENT) begin
      cond_ok = intermodule_event_bus;
    end else if (fw.cond < 3'(NUM_COND)) begin
      cond_ok = cfg.cond_mask[fw.cond[1:0]][q.pat_s2];
    end else begin
      cond_ok = 1'b0;
    end
  end

  // field widths summed into the live channel count
  always_comb begin
    fld_sum = '0;
    for (int k = 0; k < NUM_FIELDS; k++) begin
      if (cfg.fld_width[k] > FW_W'(MAX_FIELD_W)) begin
        fld_sum = fld_sum + SUM_W'(MAX_FIELD_W);
      end else begin
        fld_sum = fld_sum + SUM_W'(cfg.fld_width[k]);
      end
    end
  end

  // channels per mode, one mask bit per channel
  for (genvar i = 0; i < CHANS; i++) begin : g_mask
    assign chan_mask[i] = (SUM_W'(i) < fld_sum) &&
                          (cfg.half_mode ? (i < HALF_CHANS) : 1'b1);
  end
  assign live_mask = chan_mask;

  assign last_c = q.c_main && (q.c_addr == cfg.main_last);
  assign fw_pop = tick && fw_valid && (q.st == ST_RUN || q.st == ST_WAIT)
                  && (fw.op != OP_WAIT || cond_ok);

  // Next state of the whole sequencer
  always_comb begin
    d = q;
    d.vclk = 1'b0;
    d.arm  = 1'b0;
    d.strb = q.strb >> 1;
    d.strb[STROBE_CYC-1] = q.vclk & cfg.strobe_dly;
    d.ext_sync = {q.ext_sync[1:0], ext_clk_pin};
    d.pat_s1 = pattern_pins;
    d.pat_s2 = q.pat_s1;
    if (cfg.clk_src == CLK_INT) begin
      d.acc = gen_tick ? '0 : q.acc + ACC_W'(mhz);
    end
    // Fetch side runs ahead of consumption on the same address walk
    if (fetch_valid && fetch_ready) begin
      if (q.f_addr == cfg.main_last && q.f_main) begin
        d.f_addr = cfg.main_first;
        d.f_on   = cfg.repeat_mode;
      end else begin
        d.f_addr = wrap_addr(q.f_addr + ADDR_W'(1), cfg.half_mode);
        if (wrap_addr(q.f_addr + ADDR_W'(1), cfg.half_mode)
            == cfg.main_first) begin
          d.f_main = 1'b1;
        end
      end
    end
    unique case (q.st)
      ST_IDLE, ST_DONE: begin
        if (start) begin
          d.st     = ST_RUN;
          d.f_on   = 1'b1;
          // Start address folded too; the reload of main_first is not, so full mode can still show bit 23
          d.f_addr = wrap_addr(cfg.init_first, cfg.half_mode);
          d.c_addr = wrap_addr(cfg.init_first, cfg.half_mode);
          d.f_main = (cfg.init_first == cfg.main_first);
          d.c_main = (cfg.init_first == cfg.main_first);
          d.urun   = 1'b0;
        end
      end
      ST_RUN, ST_WAIT: begin
        if (tick && !fw_valid) begin
          d.urun = 1'b1;
        end
        if (tick && fw_valid && fw.op == OP_WAIT && !cond_ok) begin
          d.st = ST_WAIT;
        end
        if (fw_pop) begin
          d.st = ST_RUN;
          if (fw.op == OP_VEC) begin
            d.vec  = fw.data & live_mask;
            d.vclk = 1'b1;
          end
          if (fw.op == OP_ARM) begin
            d.arm = 1'b1;
          end
          if (last_c) begin
            d.c_addr = cfg.main_first;
            // single run stops, last vector held
            if (!cfg.repeat_mode) begin
              d.st = ST_DONE;
            end
          end else begin
            d.c_addr = wrap_addr(q.c_addr + ADDR_W'(1), cfg.half_mode);
            if (wrap_addr(q.c_addr + ADDR_W'(1), cfg.half_mode)
                == cfg.main_first) begin
              d.c_main = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs from flops except tick_out, which passes tick through; strobe undelayed when the delay is off
  assign fetch_valid      = q.f_on && (q.st == ST_RUN || q.st == ST_WAIT);
  assign fetch_addr       = q.f_addr;
  assign chan_out         = q.vec;
  assign vec_clk_out      = q.vclk;
  assign strobe_out       = cfg.strobe_dly ? q.strb[0] : q.vclk;
  assign tick_out         = tick;
  assign arm_peer_modules = q.arm;
  assign busy             = (q.st == ST_RUN || q.st == ST_WAIT);
  assign waiting          = (q.st == ST_WAIT);
  assign underrun         = q.urun;

  // ==========================================
  // Checks
  a_vec_on_tick: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(chan_out) |-> $past(tick) && $past(fw.op == OP_VEC))
    else $error("vector changed without an output clock");

  a_half_upper_zero: assert property (@(posedge ref_clk) disable iff (reset)
    cfg.half_mode && $past(cfg.half_mode) && vec_clk_out
      |-> chan_out[CHANS-1:HALF_CHANS] == '0)
    else $error("upper channels driven in half mode");

  a_wait_holds: assert property (@(posedge ref_clk) disable iff (reset)
    waiting && !cond_ok ##1 waiting |-> $stable(chan_out) && !vec_clk_out)
    else $error("vector advanced during a false wait");

  a_arm_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    $past(fw_pop) && $past(fw.op == OP_ARM) |-> arm_peer_modules ##1
      !arm_peer_modules || $past(fw_pop))
    else $error("arm event not raised for one cycle");

  a_strobe_delay: assert property (@(posedge ref_clk) disable iff (reset)
    vec_clk_out && cfg.strobe_dly ##1 cfg.strobe_dly |-> strobe_out)
    else $error("strobe not one cycle after vector");

  a_init_once: assert property (@(posedge ref_clk) disable iff (reset)
    q.c_main && busy && !$rose(busy) |=> q.c_main || !busy)
    else $error("init block replayed during a run");

  a_done_holds: assert property (@(posedge ref_clk) disable iff (reset)
    q.st == ST_DONE && !start |=> $stable(chan_out) && !busy)
    else $error("outputs moved after single run ended");

  a_wait_cond: assert property (@(posedge ref_clk) disable iff (reset)
    tick && fw_valid && busy && fw.op == OP_WAIT && !cond_ok
      |-> !fw_pop ##1 waiting)
    else $error("false wait condition consumed");
endmodule : svs_sequencer

`default_nettype wire

// File: dv/svs_vector_store.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Vector store model: answers fetches in order
module svs_vector_store (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          slow,
  input  wire logic          fetch_valid,
  input  wire logic [23:0]   fetch_addr,
  output logic               fetch_ready,
  output logic               word_valid,
  output var svs_pkg::svs_word_s word_in,
  input  wire logic          word_ready
);
  import svs_pkg::*;
  logic [23:0] pend[$];
  logic [23:0] fa_s;
  logic        fv_s, fr_s, wv_s, wr_s, take;
  int          cnt;

  // Program: 4 waits on cond 0, 6 arms peers, 8 waits on event
  function automatic svs_word_s word_at(logic [23:0] a);
    svs_word_s w;
    w.op   = (a[7:0] == 8'h06) ? OP_ARM :
             (a[7:0] == 8'h04 || a[7:0] == 8'h08) ? OP_WAIT : OP_VEC;
    w.cond = (a[7:0] == 8'h08) ? COND_EVENT : 3'h0;
    w.data = {a[7:0] ^ 8'h5a, 32'h9c3e71a4, a[7:0]};
    return w;
  endfunction : word_at

  initial begin
    {fetch_ready, word_valid, cnt} = '0;
    word_in = '0;
  end

  // Levels settle by the falling edge, so sample there
  always @(negedge clk) begin
    {fv_s, fr_s, wv_s, wr_s, fa_s} =
      {fetch_valid, fetch_ready, word_valid, word_ready, fetch_addr};
  end

  // Word held until taken; a stall shows a changing pattern
  always @(posedge clk) begin
    take = wv_s && wr_s;
    if (reset) begin
      pend.delete();
    end else begin
      if (take) void'(pend.pop_front());
      if (fv_s && fr_s) pend.push_back(fa_s);
    end
    cnt++;
    #1;
    fetch_ready = !reset && pend.size() < 4 && (!slow || cnt[0]);
    if (reset || take || !word_valid) begin
      word_valid = !reset && pend.size() > 0 && (!slow || cnt % 3 == 0);
      word_in = word_valid ? word_at(pend[0]) : svs_word_s'(~word_in);
    end
  end
endmodule : svs_vector_store
`default_nettype wire

// File: dv/svs_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module svs_sequencer_tb_top;
  import svs_pkg::*;
  logic        ref_clk, reset, start, ext_clk_pin, slow;
  logic        intermodule_event_bus;
  logic        chain_tick_in, fetch_valid, fetch_ready, word_valid;
  logic        word_ready, vec_clk_out, strobe_out, tick_out, busy;
  logic        arm_peer_modules, waiting, underrun, prev_vec;
  logic        full_seen, hi_seen;
  logic [2:0]  pattern_pins;
  logic [23:0] fetch_addr;
  logic [47:0] chan_out;
  logic [47:0] got[$];
  svs_cfg_s    cfg, base;
  svs_word_s   word_in;
  int          err_count, num_checks, cyc, last_cyc, gap;
  int          arm_cnt, late_cnt, tick_cnt, stb_cnt;

  // ==========================================
  // Clock, design and vector store
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  svs_sequencer dut (
    .ref_clk(ref_clk), .reset(reset), .cfg(cfg), .start(start),
    .ext_clk_pin(ext_clk_pin), .pattern_pins(pattern_pins),
    .intermodule_event_bus(intermodule_event_bus),
    .chain_tick_in(chain_tick_in),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .word_valid(word_valid),
    .word_in(word_in), .word_ready(word_ready), .chan_out(chan_out),
    .vec_clk_out(vec_clk_out), .strobe_out(strobe_out),
    .tick_out(tick_out), .arm_peer_modules(arm_peer_modules),
    .busy(busy), .waiting(waiting), .underrun(underrun));

  svs_vector_store store (
    .clk(ref_clk), .reset(reset), .slow(slow),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_ready(fetch_ready), .word_valid(word_valid),
    .word_in(word_in), .word_ready(word_ready));

  // ==========================================
  // Monitor: vectors, gaps, strobes, arm pulses, buffer refusals
  always @(negedge ref_clk) begin
    cyc++;
    if (vec_clk_out === 1'b1) begin
      got.push_back(chan_out);
      gap = cyc - last_cyc;
      last_cyc = cyc;
    end
    if (strobe_out === 1'b1 && prev_vec) late_cnt++;
    if (strobe_out === 1'b1) stb_cnt++;
    prev_vec = (vec_clk_out === 1'b1);
    if (arm_peer_modules === 1'b1) arm_cnt++;
    if (tick_out === 1'b1) tick_cnt++;
    if (word_ready === 1'b0 && !reset) full_seen = 1'b1;
    if (fetch_valid === 1'b1 && fetch_addr[23] === 1'b1) hi_seen = 1'b1;
  end

  // ==========================================
  // Reporting and compare helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic fail(string m);
    $display("CHECK FAILED at %0t: %s", $time, m);
    err_count++;
  endtask : fail

  task automatic cmp_vec(logic [47:0] g, logic [47:0] e, string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask : cmp_vec

  task automatic cmp_bit(logic g, logic e, string m);
    num_checks++;
    if (g !== e) fail(m);
  endtask : cmp_bit

  task automatic cmp_cnt(int g, int e, string m);
    num_checks++;
    if (g != e) fail($sformatf("%s got %0d want %0d", m, g, e));
  endtask : cmp_cnt

  function automatic logic [47:0] pat(int a);
    return {a[7:0] ^ 8'h5a, 32'h9c3e71a4, a[7:0]};
  endfunction : pat

  function automatic svs_cfg_s mk(svs_clk_e s, logic r, int i0, m0, m1);
    svs_cfg_s c;
    c = base;
    c.clk_src = s;
    c.repeat_mode = r;
    {c.init_first, c.main_first, c.main_last} = {i0[23:0], m0[23:0], m1[23:0]};
    return c;
  endfunction : mk

  // Config only changes under reset, when the sequencer is idle
  task automatic go(svs_cfg_s c);
    @(negedge ref_clk);
    reset = 1'b1;
    cfg = c;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    got.delete();
    {arm_cnt, late_cnt, tick_cnt, stb_cnt} = '0;
    {full_seen, hi_seen} = 2'b00;
    @(negedge ref_clk);
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
  endtask : go

  task automatic wait_vecs(int n, int lim);
    for (int i = 0; i < lim && got.size() < n; i++) @(negedge ref_clk);
    if (got.size() < n) begin
      fail("timeout waiting for vectors");
      tally_and_finish();
    end
  endtask : wait_vecs

  task automatic check_seq(int a[$]);
    foreach (a[k]) cmp_vec(got[k], pat(a[k]), "vector out of order");
  endtask : check_seq

  // ==========================================
  // Scenarios
  task automatic t_single();
    go(mk(CLK_INT, 1'b0, 0, 1, 3));
    wait_vecs(4, 200);
    repeat (30) @(negedge ref_clk);
    check_seq('{0, 1, 2, 3});
    cmp_cnt(got.size(), 4, "single run count");
    cmp_bit(busy, 1'b0, "busy after single run");
    cmp_vec(chan_out, pat(3), "last vector held");
    cmp_cnt(gap, 5, "2 MHz tick spacing");
    cmp_cnt(late_cnt, 0, "undelayed strobe late");
    cmp_cnt(stb_cnt, 4, "undelayed strobe count");
    $display("t_single done");
  endtask : t_single

  task automatic t_repeat();
    slow = 1'b1;
    base.gen_mhz = 9'h001;
    base.strobe_dly = 1'b1;
    go(mk(CLK_INT, 1'b1, 0, 2, 3));
    wait_vecs(8, 400);
    repeat (3) @(negedge ref_clk);
    check_seq('{0, 1, 2, 3, 2, 3, 2, 3});
    cmp_cnt(late_cnt, got.size(), "late strobes");
    cmp_cnt(stb_cnt, got.size(), "strobe count");
    repeat (100) @(negedge ref_clk);
    cmp_bit(full_seen, 1'b1, "buffer never refused");
    {slow, base.strobe_dly, base.gen_mhz} = {2'b00, 9'h002};
    $display("t_repeat done");
  endtask : t_repeat

  task automatic t_wait();
    go(mk(CLK_INT, 1'b0, 4, 5, 5));
    repeat (60) @(negedge ref_clk);
    cmp_cnt(got.size(), 0, "output during wait");
    cmp_bit(waiting, 1'b1, "waiting flag");
    pattern_pins = 3'h4;
    repeat (30) @(negedge ref_clk);
    cmp_cnt(got.size(), 0, "unselected pattern");
    pattern_pins = 3'h5;
    wait_vecs(1, 60);
    check_seq('{5});
    pattern_pins = 3'h0;
    $display("t_wait done");
  endtask : t_wait

  task automatic t_arm();
    go(mk(CLK_INT, 1'b0, 6, 7, 9));
    repeat (60) @(negedge ref_clk);
    cmp_cnt(arm_cnt, 1, "arm pulses");
    cmp_cnt(got.size(), 1, "event wait stall");
    intermodule_event_bus = 1'b1;
    wait_vecs(2, 60);
    intermodule_event_bus = 1'b0;
    check_seq('{7, 9});
    $display("t_arm done");
  endtask : t_arm

  task automatic t_src();
    svs_clk_e s;
    for (int j = 0; j < 2; j++) begin
      s = (j == 0) ? CLK_EXT : CLK_CHAIN;
      go(mk(s, 1'b0, 0, 1, 3));
      repeat (40) @(negedge ref_clk);
      cmp_cnt(got.size(), 0, "vector with no edge");
      for (int k = 0; k < 4; k++) begin
        // pod clock, 800 ns, runs only in the frame
        if (j == 0) begin
          #33 ext_clk_pin = 1'b1;
          #400 ext_clk_pin = 1'b0;
          #367;
        end else begin
          chain_tick_in = 1'b1;
          @(negedge ref_clk);
          chain_tick_in = 1'b0;
          repeat (7) @(negedge ref_clk);
        end
      end
      repeat (10) @(negedge ref_clk);
      check_seq('{0, 1, 2, 3});
      cmp_cnt(got.size(), 4, "one vector per edge");
      cmp_cnt(tick_cnt, 4, "forwarded ticks");
      cmp_bit(underrun, 1'b0, "underrun with full buffer");
    end
    $display("t_src done");
  endtask : t_src

  task automatic t_fields();
    for (int k = 0; k < 2; k++) begin
      base.half_mode = (k == 0);
      base.fld_width = (k == 0) ? {6'h04, 6'h04, 6'h04}
                                : {6'h00, 6'h08, 6'h28};
      go(mk(CLK_INT, 1'b0, 24'h800000, 24'h800001, 24'h800001));
      wait_vecs(2, 100);
      cmp_vec(got[1], pat(1) & ((k == 0) ? 48'hfff : 48'hff_ffff_ffff),
              "live channel mask");
      cmp_bit(hi_seen, k == 0, "address bit 23");
    end
    $display("t_fields done");
  endtask : t_fields

  // ==========================================
  // Main sequence
  initial begin
    {reset, start, ext_clk_pin, chain_tick_in, slow} = 5'h10;
    intermodule_event_bus = 1'b0;
    {err_count, num_checks, cyc, last_cyc, gap} = '0;
    {prev_vec, full_seen, hi_seen} = 3'h0;
    pattern_pins = 3'h0;
    base = '0;
    base.gen_mhz = 9'h002;
    base.fld_width = {6'h10, 6'h10, 6'h10};
    base.cond_mask = {8'hff, 8'hff, 8'hff, 8'h20};
    cfg = base;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    t_single();
    t_repeat();
    t_wait();
    t_arm();
    t_src();
    t_fields();
    tally_and_finish();
  end
endmodule : svs_sequencer_tb_top
`default_nettype wire
